// ===== src/adc_port_map.vh
// Purpose: Register map, field positions and timing counts of the dual sample output port.
// Assumes: Included by bare name; definitions only.
// Notes: Byte addresses on an 8-bit register address port with 32-bit data.
`ifndef ADC_PORT_MAP_VH
`define ADC_PORT_MAP_VH

`define ADDR_W 8
`define DATA_W 32

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_PINS 8'h0c
`define REG_WORD_A 8'h10
`define REG_WORD_B 8'h14
`define REG_COUNT 8'h18
`define REG_DIV 8'h1c
`define REG_OVR_CNT_A 8'h20
`define REG_OVR_CNT_B 8'h24

`define CTRL_W 3
`define CTRL_SWAP_A 0
`define CTRL_SWAP_B 1
`define CTRL_RUN 2
`define CTRL_RST 3'h4

`define EV_W 3
`define EV_OVR_A 0
`define EV_OVR_B 1
`define EV_CFG 2
`define STATUS_RST 3'h0
`define MASK_RST 3'h0

`define PINS_RANGE 0
`define PINS_REF 1
`define PINS_OE_N_A 2
`define PINS_OE_N_B 3

`define WORD_OVR_BIT 12

`define DIV_W 8
`define DIV_RST 8'h00

`define CNT_W 16
`define CNT_RST 16'h0000

`define LATENCY 6
`define SAMPLE_W 12
`define IN_W 14

`endif

// ===== src/dual_adc_sample_output_port.v
// Purpose: Digital output side of a dual 12-bit pipelined converter with a
// register port for control, event status and interrupt.
// Assumes: All inputs synchronous to clk_sys; sample inputs are signed
// differential values in LSB units of the 3V range.
// Notes: The conversion clock is clk_sys divided by the divider register plus one.
// The register port never stalls; read data stand for one cycle only.
`timescale 1ns/10ps
`default_nettype none
`include "adc_port_map.vh"

module dual_adc_sample_output_port #(
  parameter W = `SAMPLE_W,
  parameter IN_W = `IN_W,
  parameter LATENCY = `LATENCY
) (
  input wire clk_sys,
  input wire rstn,
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [`DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`DATA_W-1:0] reg_rdata,
  output wire irq,
  input wire [IN_W-1:0] sample_in_a,
  input wire [IN_W-1:0] sample_in_b,
  input wire range_pick,
  input wire reference_source_pick,
  input wire out_enable_n_a,
  input wire out_enable_n_b,
  output wire [W-1:0] data_a,
  output wire data_oe_a,
  output wire over_range_flag_a,
  output wire over_range_oe_a,
  output wire sample_valid_strobe_a,
  output wire [W-1:0] data_b,
  output wire data_oe_b,
  output wire over_range_flag_b,
  output wire over_range_oe_b,
  output wire sample_valid_strobe_b
);

  // Fixed channel count; the per-channel logic below is one generate loop.
  localparam NCH = 2;
  localparam top_bit = W - 1;
  localparam bottom_bit = 0;
  localparam PW = W + 1;
  localparam SW = IN_W + 3;
  // The clamp limits are the two's-complement end codes, sign-extended to the
  // width of the scaled value, so no integer constant is cut silently.
  localparam signed [SW-1:0] FS_MAX = {{(SW-W+1){1'b0}}, {(W-1){1'b1}}};
  localparam signed [SW-1:0] FS_MIN = {{(SW-W+1){1'b1}}, {(W-1){1'b0}}};

  // Control and status state.
  reg [`CTRL_W-1:0] ctrl;
  reg [`EV_W-1:0] status;
  reg [`EV_W-1:0] mask;
  reg [`DIV_W-1:0] div;
  reg [`DIV_W-1:0] div_cnt;
  reg [`CNT_W-1:0] conv_count;
  reg range_q;
  reg ref_q;
  reg conv_en;
  reg present;

  wire [IN_W-1:0] chan_in [0:NCH-1];
  wire [NCH-1:0] swap;
  wire [NCH-1:0] oe_n;
  // Line outputs: flag in the top bit, offset-binary word below it.
  wire [PW-1:0] pipe_out [0:NCH-1];
  reg [NCH-1:0] strobe;
  reg [`CNT_W-1:0] ovr_cnt [0:NCH-1];
  wire [NCH-1:0] ovr_event;
  wire cfg_event;
  reg [`EV_W-1:0] next_status;
  reg [`DATA_W-1:0] next_rdata;

  assign chan_in[0] = sample_in_a;
  assign chan_in[1] = sample_in_b;
  // The swap bits stand for a signal wired to the complementary input; they
  // are static settings, and a change reaches the pins after the latency.
  assign swap[0] = ctrl[`CTRL_SWAP_A];
  assign swap[1] = ctrl[`CTRL_SWAP_B];
  assign oe_n[0] = out_enable_n_a;
  assign oe_n[1] = out_enable_n_b;

  // The conversion clock is an enable pulse; a divider of zero converts on
  // every clk_sys edge, which is already below the fastest rate of the core.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= {`DIV_W{1'b0}};
      conv_en <= 1'b0;
    end else if (!ctrl[`CTRL_RUN]) begin
      div_cnt <= {`DIV_W{1'b0}};
      conv_en <= 1'b0;
    end else if (div_cnt >= div) begin
      div_cnt <= {`DIV_W{1'b0}};
      conv_en <= 1'b1;
    end else begin
      div_cnt <= div_cnt + {{(`DIV_W-1){1'b0}}, 1'b1};
      conv_en <= 1'b0;
    end
  end

  // One cycle after a conversion edge the new words stand at the pins.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      present <= 1'b0;
    end else begin
      present <= conv_en;
    end
  end

  // Each channel runs the same path: optional negation for the complementary
  // input, range gain, clamp at full scale, offset coding and the latency line.
  // The over-range flag rides in the top bit of the line so that it can never
  // drift away from the word it belongs to.
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_chan
      wire signed [IN_W:0] ext;
      wire signed [IN_W:0] turned;
      wire signed [SW-1:0] wide;
      wire signed [SW-1:0] scaled;
      wire hi;
      wire lo;
      wire [W-1:0] twos;
      wire [W-1:0] code;

      assign ext = {chan_in[c][IN_W-1], chan_in[c]};
      // Signal on the complementary input: the code is the negated signal.
      assign turned = swap[c] ? -ext : ext;
      assign wide = {{2{turned[IN_W]}}, turned};
      // Inputs are in 3V-range units; the 2V range has 3/2 the gain.
      assign scaled = range_pick ? wide : ((wide + (wide <<< 1)) >>> 1);
      assign hi = scaled > FS_MAX;
      assign lo = scaled < FS_MIN;
      // Clamping keeps the full code set reachable with the end codes held
      // while the input is beyond full scale.
      assign twos = hi ? {1'b0, {(W-1){1'b1}}} :
                    lo ? {1'b1, {(W-1){1'b0}}} : scaled[W-1:0];
      // Offset binary is two's complement with the top bit turned over.
      assign code = {~twos[top_bit], twos[top_bit-1:bottom_bit]};

      sample_delay_line #(
        .W(PW),
        .DEPTH(LATENCY + 1)
      ) u_line (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .advance(conv_en),
        .din({hi | lo, code}),
        .dout(pipe_out[c])
      );

      // The strobe changes in the same cycle as the word, so either of its
      // edges marks a stable new word for the capturing logic.
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          strobe[c] <= 1'b0;
        end else if (conv_en) begin
          strobe[c] <= ~strobe[c];
        end
      end

      assign ovr_event[c] = present & pipe_out[c][W];

      // The counter saturates instead of wrapping, so a long overload never
      // reads back as a small count.
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          ovr_cnt[c] <= `CNT_RST;
        end else if (reg_wr && reg_addr == (c == 0 ? `REG_OVR_CNT_A : `REG_OVR_CNT_B)) begin
          ovr_cnt[c] <= `CNT_RST;
        end else if (ovr_event[c] && ovr_cnt[c] != {`CNT_W{1'b1}}) begin
          ovr_cnt[c] <= ovr_cnt[c] + {{(`CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  endgenerate

  // Pin outputs: words and flags come straight from the pipeline flops.
  assign data_a = pipe_out[0][top_bit:bottom_bit];
  assign data_b = pipe_out[1][top_bit:bottom_bit];
  assign over_range_flag_a = pipe_out[0][W];
  assign over_range_flag_b = pipe_out[1][W];
  // The enables act at once and do not wait for a conversion edge, as the
  // capture side uses them to share one bus between the two channels.
  assign data_oe_a = ~oe_n[0];
  assign data_oe_b = ~oe_n[1];
  assign over_range_oe_a = ~oe_n[0];
  assign over_range_oe_b = ~oe_n[1];
  assign sample_valid_strobe_a = strobe[0];
  assign sample_valid_strobe_b = strobe[1];

  // A change of range or reference invalidates the words still in flight.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      range_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      range_q <= range_pick;
      ref_q <= reference_source_pick;
    end
  end

  // The first cycle after reset compares against reset values of the pin
  // copies, not against real pin levels, so the event is held off until then.
  reg cfg_armed;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_armed <= 1'b0;
    end else begin
      cfg_armed <= 1'b1;
    end
  end

  assign cfg_event = cfg_armed & ((range_q != range_pick) | (ref_q != reference_source_pick));

  // The count follows the words at the pins, one cycle behind the conversion
  // edge, so it agrees with the status events raised from the same words.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      conv_count <= `CNT_RST;
    end else if (reg_wr && reg_addr == `REG_COUNT) begin
      conv_count <= `CNT_RST;
    end else if (present) begin
      conv_count <= conv_count + {{(`CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Write-one-to-clear; an event in the clearing cycle stays set.
  always @* begin
    next_status = status;
    if (reg_wr && reg_addr == `REG_STATUS) begin
      next_status = status & ~reg_wdata[`EV_W-1:0];
    end
    next_status[`EV_OVR_A] = next_status[`EV_OVR_A] | ovr_event[0];
    next_status[`EV_OVR_B] = next_status[`EV_OVR_B] | ovr_event[1];
    next_status[`EV_CFG] = next_status[`EV_CFG] | cfg_event;
  end

  // Writes to read-only or unmapped offsets are ignored; the counters decode
  // their own offsets, as any write to them clears them.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `CTRL_RST;
      mask <= `MASK_RST;
      div <= `DIV_RST;
      status <= `STATUS_RST;
    end else begin
      status <= next_status;
      if (reg_wr) begin
        case (reg_addr)
          `REG_CTRL: begin
            ctrl <= reg_wdata[`CTRL_W-1:0];
          end
          `REG_MASK: begin
            mask <= reg_wdata[`EV_W-1:0];
          end
          `REG_DIV: begin
            div <= reg_wdata[`DIV_W-1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // The interrupt drops right after the edge that clears or masks the last
  // pending bit, as both status and mask are flops.
  assign irq = |(status & mask);

  // The read mux looks only at the address; the strobe gates the flop below,
  // so reading never has side effects on status or counters.
  always @* begin
    next_rdata = {`DATA_W{1'b0}};
    case (reg_addr)
      `REG_CTRL: begin
        next_rdata[`CTRL_W-1:0] = ctrl;
      end
      `REG_STATUS: begin
        next_rdata[`EV_W-1:0] = status;
      end
      `REG_MASK: begin
        next_rdata[`EV_W-1:0] = mask;
      end
      `REG_PINS: begin
        next_rdata[`PINS_RANGE] = range_pick;
        next_rdata[`PINS_REF] = reference_source_pick;
        next_rdata[`PINS_OE_N_A] = out_enable_n_a;
        next_rdata[`PINS_OE_N_B] = out_enable_n_b;
      end
      `REG_WORD_A: begin
        next_rdata[PW-1:0] = pipe_out[0];
      end
      `REG_WORD_B: begin
        next_rdata[PW-1:0] = pipe_out[1];
      end
      `REG_COUNT: begin
        next_rdata[`CNT_W-1:0] = conv_count;
      end
      `REG_DIV: begin
        next_rdata[`DIV_W-1:0] = div;
      end
      `REG_OVR_CNT_A: begin
        next_rdata[`CNT_W-1:0] = ovr_cnt[0];
      end
      `REG_OVR_CNT_B: begin
        next_rdata[`CNT_W-1:0] = ovr_cnt[1];
      end
      default: begin
        next_rdata = {`DATA_W{1'b0}};
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe and are zero otherwise.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= {`DATA_W{1'b0}};
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= {`DATA_W{1'b0}};
    end
  end

endmodule // dual_adc_sample_output_port

`default_nettype wire

// ===== src/sample_delay_line.v
// Purpose: Fixed-length shift line that models the converter pipeline latency.
// Assumes: One clock; advance is a one-cycle enable at the conversion rate.
// Notes: Stage 0 is the sampling stage, so a word taken on one advance
// reaches the output on the DEPTH-1 th advance after it.
`timescale 1ns/10ps
`default_nettype none

module sample_delay_line #(
  parameter W = 13,
  parameter DEPTH = 7
) (
  input wire clk_sys,
  input wire rstn,
  input wire advance,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] stage [0:DEPTH-1];

  genvar s;
  generate
    for (s = 0; s < DEPTH; s = s + 1) begin : g_stage
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          stage[s] <= {W{1'b0}};
        end else if (advance) begin
          if (s == 0) begin
            stage[s] <= din;
          end else begin
            stage[s] <= stage[(s == 0) ? 0 : s - 1];
          end
        end
      end
    end
  endgenerate

  assign dout = stage[DEPTH-1];

endmodule // sample_delay_line

`default_nettype wire

// ===== testbench/capture_model.sv
// Purpose: Capture logic on the far side of one channel.
// Assumes: Strobe toggles once per word.
// Notes: Released pins read as the inverse of the last value seen.
`timescale 1ns/10ps
`default_nettype none
module capture_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [11:0] data,
  input wire logic data_oe,
  input wire logic flag,
  input wire logic flag_oe,
  input wire logic strobe,
  output logic [12:0] captured
);
  logic [12:0] last;
  logic prev;
  wire [12:0] pins = {flag_oe ? flag : ~last[12], data_oe ? data : ~last[11:0]};
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      last <= 13'h0000;
      prev <= 1'b0;
      captured <= 13'h0000;
    end else begin
      last <= pins;
      prev <= strobe;
      if (strobe != prev) begin
        captured <= pins;
      end
    end
  end
endmodule // capture_model
`default_nettype wire

// ===== testbench/dual_adc_port_assertions.sv
// Purpose: Port checker for the dual sample output port.
// Assumes: Bound to the top module; one clock domain.
// Notes: Latency is judged by the bench, as conversion timing is internal.
`timescale 1ns/10ps
`default_nettype none
module dual_adc_port_checker #(parameter W = 12) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic out_enable_n_a,
  input wire logic out_enable_n_b,
  input wire logic data_oe_a,
  input wire logic data_oe_b,
  input wire logic over_range_oe_a,
  input wire logic [W-1:0] data_a,
  input wire logic [W-1:0] data_b,
  input wire logic over_range_flag_a,
  input wire logic over_range_flag_b,
  input wire logic sample_valid_strobe_a,
  input wire logic sample_valid_strobe_b
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_oe_follows_a: assert property (data_oe_a == !out_enable_n_a) else $error("oe a");
  a_oe_follows_b: assert property (data_oe_b == !out_enable_n_b) else $error("oe b");
  a_flag_oe_a: assert property (over_range_oe_a == data_oe_a) else $error("flag oe a");
  a_word_strobe_a: assert property (
    $changed(data_a) |-> $changed(sample_valid_strobe_a))
    else $error("word a moved without strobe");
  a_word_strobe_b: assert property (
    $changed(data_b) |-> $changed(sample_valid_strobe_b))
    else $error("word b moved without strobe");
  a_flag_strobe_a: assert property (
    $changed(over_range_flag_a) |-> $changed(sample_valid_strobe_a))
    else $error("flag a moved without strobe");
  a_flag_code_a: assert property (
    over_range_flag_a |-> data_a == '1 || data_a == '0)
    else $error("flag a with inner code");
  a_flag_code_b: assert property (
    over_range_flag_b |-> data_b == '1 || data_b == '0)
    else $error("flag b with inner code");
  c_flag_a: cover property ($rose(over_range_flag_a));
  c_released_a: cover property (!data_oe_a);
  c_top_code: cover property (data_b == '1);
endmodule // dual_adc_port_checker
bind dual_adc_sample_output_port dual_adc_port_checker #(.W(W)) i_dual_adc_port_checker (
  .clk_sys(clk_sys), .rstn(rstn), .out_enable_n_a(out_enable_n_a),
  .out_enable_n_b(out_enable_n_b), .data_oe_a(data_oe_a), .data_oe_b(data_oe_b),
  .over_range_oe_a(over_range_oe_a), .data_a(data_a), .data_b(data_b),
  .over_range_flag_a(over_range_flag_a), .over_range_flag_b(over_range_flag_b),
  .sample_valid_strobe_a(sample_valid_strobe_a), .sample_valid_strobe_b(sample_valid_strobe_b));
`default_nettype wire

// ===== testbench/dual_adc_sample_output_port_tb.sv
// Purpose: Self-checking bench for the dual sample output port.
// Assumes: Divider at 0, so every clock is a conversion, except in the divider
// scenario, which restores it.
// Notes: Inputs are held long enough for the pipeline to flush.
`timescale 1ns/10ps
`default_nettype none
`include "adc_port_map.vh"
module dual_adc_sample_output_port_tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [13:0] sample_in_a = 14'h0000;
  logic [13:0] sample_in_b = 14'h0000;
  logic range_pick = 1'b1;
  logic reference_source_pick = 1'b1;
  logic out_enable_n_a = 1'b0;
  logic out_enable_n_b = 1'b0;
  wire [31:0] reg_rdata;
  wire [11:0] data_a, data_b;
  wire irq, data_oe_a, data_oe_b, ovr_a, ovr_b, ovr_oe_a, ovr_oe_b, stb_a, stb_b;
  wire [12:0] cap_a, cap_b;
  logic [31:0] rd;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  always #20 clk_sys = ~clk_sys;
  dual_adc_sample_output_port i_dual_adc_sample_output_port (.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .sample_in_a(sample_in_a), .sample_in_b(sample_in_b),
    .range_pick(range_pick), .reference_source_pick(reference_source_pick),
    .out_enable_n_a(out_enable_n_a), .out_enable_n_b(out_enable_n_b), .data_a(data_a),
    .data_oe_a(data_oe_a), .over_range_flag_a(ovr_a), .over_range_oe_a(ovr_oe_a),
    .sample_valid_strobe_a(stb_a), .data_b(data_b), .data_oe_b(data_oe_b),
    .over_range_flag_b(ovr_b), .over_range_oe_b(ovr_oe_b), .sample_valid_strobe_b(stb_b));
  capture_model i_capture_model_a (.clk_sys(clk_sys), .rstn(rstn), .data(data_a),
    .data_oe(data_oe_a), .flag(ovr_a), .flag_oe(ovr_oe_a), .strobe(stb_a), .captured(cap_a));
  capture_model i_capture_model_b (.clk_sys(clk_sys), .rstn(rstn), .data(data_b),
    .data_oe(data_oe_b), .flag(ovr_b), .flag_oe(ovr_oe_b), .strobe(stb_b), .captured(cap_b));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Holds both inputs for a full pipeline flush, then checks words, flags and captures.
  task automatic apply(input logic [13:0] va, input logic [12:0] ea, input logic [12:0] eb);
    @(posedge clk_sys);
    sample_in_a <= va;
    sample_in_b <= va;
    repeat (9) @(posedge clk_sys);
    #1;
    check("word a", {ovr_a, data_a}, ea);
    check("word b", {ovr_b, data_b}, eb);
    check("capture a", cap_a, ea);
    check("capture b", cap_b, eb);
  endtask
  task automatic t_regs;
    reg_read(`REG_CTRL, rd);
    check("ctrl", rd, 32'h4);
    reg_read(`REG_MASK, rd);
    check("mask", rd, 32'h0);
    reg_read(8'h30, rd);
    check("unmapped", rd, 32'h0);
  endtask
  task automatic t_latency;
    @(posedge clk_sys);
    sample_in_a <= 14'h0123;
    repeat (6) @(posedge clk_sys);
    #1 check("early word", data_a, 12'h800);
    @(posedge clk_sys);
    #1 check("late word", data_a, 12'h923);
    reg_read(`REG_WORD_A, rd);
    check("word reg a", rd, 32'h923);
  endtask
  task automatic t_codes;
    apply(14'h0bb8, 13'h1fff, 13'h1fff);
    apply(14'h3448, 13'h1000, 13'h1000);
    apply(14'h07ff, 13'h0fff, 13'h0fff);
    apply(14'h3800, 13'h0000, 13'h0000);
    reg_write(`REG_CTRL, 32'h5);
    apply(14'h0064, 13'h079c, 13'h0864);
    reg_write(`REG_CTRL, 32'h4);
    range_pick <= 1'b0;
    apply(14'h0064, 13'h0896, 13'h0896);
    apply(14'h0578, 13'h1fff, 13'h1fff);
    reference_source_pick <= 1'b0;
    reg_read(`REG_PINS, rd);
    check("pins", rd, 32'h0);
    range_pick <= 1'b1;
    reference_source_pick <= 1'b1;
    apply(14'h0000, 13'h0800, 13'h0800);
  endtask
  task automatic t_irq;
    reg_write(`REG_OVR_CNT_A, 32'h0);
    reg_write(`REG_STATUS, 32'h7);
    reg_write(`REG_MASK, 32'h1);
    #1 check("irq idle", irq, 1'b0);
    apply(14'h0bb8, 13'h1fff, 13'h1fff);
    check("irq set", irq, 1'b1);
    reg_write(`REG_MASK, 32'h0);
    #1 check("irq masked", irq, 1'b0);
    apply(14'h0000, 13'h0800, 13'h0800);
    reg_write(`REG_STATUS, 32'h3);
    reg_read(`REG_STATUS, rd);
    check("status", rd, 32'h0);
    // Twelve samples are taken over range between the two input changes.
    reg_read(`REG_OVR_CNT_A, rd);
    check("ovr count a", rd, 32'hc);
  endtask
  task automatic t_oe;
    @(posedge clk_sys);
    out_enable_n_a <= 1'b1;
    #1 check("oe a", {data_oe_a, ovr_oe_a, data_oe_b}, 3'b001);
    reg_read(`REG_PINS, rd);
    check("pins oe", rd, 32'h7);
    @(posedge clk_sys);
    out_enable_n_a <= 1'b0;
    out_enable_n_b <= 1'b1;
    #1 check("oe b", {data_oe_a, data_oe_b, ovr_oe_a, ovr_oe_b}, 4'b1010);
  endtask
  // Slower conversion rate and the run bit: the strobe marks conversions only.
  task automatic t_div;
    logic s0;
    reg_write(`REG_DIV, 32'h2);
    reg_read(`REG_DIV, rd);
    check("div", rd, 32'h2);
    #1 s0 = stb_a;
    repeat (3) @(posedge clk_sys);
    #1 check("slow strobe", stb_a ^ s0, 1'b1);
    reg_write(`REG_CTRL, 32'h0);
    repeat (2) @(posedge clk_sys);
    reg_write(`REG_COUNT, 32'h0);
    #1 s0 = stb_a;
    repeat (4) @(posedge clk_sys);
    #1 check("frozen strobe", stb_a, s0);
    reg_read(`REG_COUNT, rd);
    check("frozen count", rd, 32'h0);
    reg_write(`REG_DIV, 32'h0);
    reg_write(`REG_CTRL, 32'h4);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 check("reset word", {ovr_a, data_a, irq}, 14'h0000);
    @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_latency();
    t_codes();
    t_irq();
    t_oe();
    t_div();
    wrap_up();
  end
endmodule // dual_adc_sample_output_port_tb
`default_nettype wire
